// ---- logic/mpm_pkg.sv ----
package mpm_pkg;
    // Clock and switching frequency range
    localparam int CLK_HZ = 125_000_000;
    localparam int FSW_MIN_HZ = 200_000;
    localparam int FSW_MAX_HZ = 1_000_000;
    localparam logic [15:0] PER_MIN = 16'(CLK_HZ / FSW_MAX_HZ);
    localparam logic [15:0] PER_MAX = 16'(CLK_HZ / FSW_MIN_HZ);
    localparam logic [15:0] PER_RST = 16'h00FA;
    // Boot refresh low-side pulse width
    localparam int REFR_W_NS = 200;
    localparam int CLK_NS = 8;
    localparam logic [7:0] REFR_W_CYC =
        8'((REFR_W_NS + CLK_NS - 1) / CLK_NS);
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_MAP = 8'h04;
    localparam logic [7:0] OFF_PER = 8'h08;
    localparam logic [7:0] OFF_PW0 = 8'h0C;
    localparam logic [7:0] OFF_PW1 = 8'h10;
    localparam logic [7:0] OFF_TH = 8'h14;
    localparam logic [7:0] OFF_DLY = 8'h18;
    localparam logic [7:0] OFF_FAST = 8'h1C;
    localparam logic [7:0] OFF_REFR = 8'h20;
    localparam logic [7:0] OFF_VOUT = 8'h24;
    localparam logic [7:0] OFF_VLIM = 8'h3C;
    localparam logic [7:0] OFF_STAT = 8'h44;
    localparam logic [7:0] OFF_IMEAS = 8'h48;
    localparam logic [7:0] OFF_TCOMP = 8'h4C;
    // Control bits and margin codes
    localparam int CTRL_EN = 0;
    localparam int CTRL_AUTO = 1;
    localparam int CTRL_MRG = 2;
    localparam logic [1:0] MRG_HI = 2'h1;
    localparam logic [1:0] MRG_LO = 2'h2;
    // Field positions of map, status and limits
    localparam int MAP_USED = 8;
    localparam int STAT_ADDR = 8;
    localparam int STAT_CFG = 16;
    localparam int HI_HALF = 16;
    // Reference temperature of current sense, degrees C
    localparam logic signed [8:0] T_REF = 9'sh019;
    localparam int TC_SH = 16;
    // Strap level to target address, level 0 in the low bits
    localparam logic [111:0] ADDR_LUT = {
        7'h5D, 7'h5C, 7'h59, 7'h58, 7'h55, 7'h54, 7'h51, 7'h50,
        7'h45, 7'h44, 7'h41, 7'h40, 7'h65, 7'h64, 7'h61, 7'h60};
    // Strap capture states
    typedef enum logic [3:0] {
        MPM_SYNC = 4'h1,
        MPM_SETTLE = 4'h2,
        MPM_LATCH = 4'h4,
        MPM_RUN = 4'h8
    } mpm_strap_t;
endpackage

// ---- logic/mpm_phase_mgr.sv ----
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/10ps
module mpm_phase_mgr #(
    parameter int NPH = 7
) (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic [3:0]         address_strap_pin,
    input  wire logic [2:0]         config_strap_pin,
    input  wire logic [15:0]        i_sense0,
    input  wire logic [15:0]        i_sense1,
    input  wire logic signed [7:0]  temp_sense,
    input  wire logic signed [15:0] reg_err0,
    input  wire logic signed [15:0] reg_err1,
    output logic      [NPH-1:0]     pwm_out,
    output logic      [NPH-1:0]     pwm_en,
    output logic      [NPH-1:0]     lowside_on,
    output logic      [6:0]         pmbus_addr,
    output logic      [2:0]         config_index,
    output logic      [15:0]        vout_target0,
    output logic      [15:0]        vout_target1
);
    if (NPH < 1 || NPH > 7) begin : g_chk
        $error("NPH must be 1 to 7");
    end

    logic [31:0] ctrl_reg, ctrl_next, map_reg, map_next, th_reg, th_next;
    logic [31:0] pw_reg [2], pw_next [2], vlim_reg [2], vlim_next [2];
    logic [15:0] per_reg, per_next, dly_reg, dly_next, refr_reg;
    logic [15:0] refr_next, fast_reg, fast_next, vreg_reg [6];
    logic [15:0] vreg_next [6], icor_reg [2], icor_next [2];
    logic [7:0]  tc_reg, tc_next;
    logic [31:0] prdata_next;
    logic        wr, rd_setup, hit;
    logic [15:0] wv;
    logic [3:0]  sa_s1, sa_s2;
    logic [2:0]  cs_s1, cs_s2;
    mpm_pkg::mpm_strap_t st_reg, st_next;
    logic [6:0]  addr_next;
    logic [2:0]  cfg_next;

    assign wr = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit;
    assign wv = pwdata[15:0];

    // Register file writes and read data capture
    always_comb
    begin
        ctrl_next = ctrl_reg;
        map_next = map_reg;
        per_next = per_reg;
        th_next = th_reg;
        dly_next = dly_reg;
        fast_next = fast_reg;
        refr_next = refr_reg;
        tc_next = tc_reg;
        pw_next = pw_reg;
        vlim_next = vlim_reg;
        vreg_next = vreg_reg;
        prdata_next = prdata;
        hit = 1'b1;
        case (paddr)
            mpm_pkg::OFF_CTRL: prdata_next = ctrl_reg;
            mpm_pkg::OFF_MAP: prdata_next = map_reg;
            mpm_pkg::OFF_PER: prdata_next = {16'h0000, per_reg};
            mpm_pkg::OFF_PW0: prdata_next = pw_reg[0];
            mpm_pkg::OFF_PW1: prdata_next = pw_reg[1];
            mpm_pkg::OFF_TH: prdata_next = th_reg;
            mpm_pkg::OFF_DLY: prdata_next = {16'h0000, dly_reg};
            mpm_pkg::OFF_FAST: prdata_next = {16'h0000, fast_reg};
            mpm_pkg::OFF_REFR: prdata_next = {16'h0000, refr_reg};
            mpm_pkg::OFF_VLIM: prdata_next = vlim_reg[0];
            mpm_pkg::OFF_VLIM + 8'h04: prdata_next = vlim_reg[1];
            mpm_pkg::OFF_STAT: prdata_next = 32'({config_index, 1'b0,
                pmbus_addr, 1'b0, 7'(pwm_en)});
            mpm_pkg::OFF_IMEAS: prdata_next = {icor_reg[1], icor_reg[0]};
            mpm_pkg::OFF_TCOMP: prdata_next = {24'h000000, tc_reg};
            default:
            begin
                hit = 1'b0;
                prdata_next = 32'h00000000;
                for (int k = 0; k < 6; k++)
                    if (paddr == mpm_pkg::OFF_VOUT + 8'(4 * k))
                    begin
                        hit = 1'b1;
                        prdata_next = {16'h0000, vreg_reg[k]};
                    end
            end
        endcase
        if (!rd_setup)
            prdata_next = prdata;
        if (wr)
        begin
            case (paddr)
                mpm_pkg::OFF_CTRL: ctrl_next = pwdata;
                mpm_pkg::OFF_MAP: map_next = pwdata;
                mpm_pkg::OFF_PER:
                    per_next = wv < mpm_pkg::PER_MIN ? mpm_pkg::PER_MIN :
                        wv > mpm_pkg::PER_MAX ? mpm_pkg::PER_MAX : wv;
                mpm_pkg::OFF_PW0: pw_next[0] = pwdata;
                mpm_pkg::OFF_PW1: pw_next[1] = pwdata;
                mpm_pkg::OFF_TH: th_next = pwdata;
                mpm_pkg::OFF_DLY: dly_next = wv;
                mpm_pkg::OFF_FAST: fast_next = wv;
                mpm_pkg::OFF_REFR: refr_next = wv;
                mpm_pkg::OFF_VLIM: vlim_next[0] = pwdata;
                mpm_pkg::OFF_VLIM + 8'h04: vlim_next[1] = pwdata;
                mpm_pkg::OFF_TCOMP: tc_next = pwdata[7:0];
                default:
                    for (int k = 0; k < 6; k++)
                        if (paddr == mpm_pkg::OFF_VOUT + 8'(4 * k))
                            vreg_next[k] = wv;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_reg <= 32'h00000000;
            map_reg <= 32'h00000000;
            per_reg <= mpm_pkg::PER_RST;
            th_reg <= 32'h00000000;
            dly_reg <= 16'h0000;
            fast_reg <= 16'h7FFF;
            refr_reg <= 16'h0000;
            tc_reg <= 8'h00;
            pw_reg <= '{default: 32'h00000000};
            vlim_reg <= '{default: 32'hFFFF0000};
            vreg_reg <= '{default: 16'h0000};
            prdata <= 32'h00000000;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            map_reg <= map_next;
            per_reg <= per_next;
            th_reg <= th_next;
            dly_reg <= dly_next;
            fast_reg <= fast_next;
            refr_reg <= refr_next;
            tc_reg <= tc_next;
            pw_reg <= pw_next;
            vlim_reg <= vlim_next;
            vreg_reg <= vreg_next;
            prdata <= prdata_next;
        end
    end

    // Strap capture once the synchronisers have settled
    always_comb
    begin
        st_next = st_reg;
        addr_next = pmbus_addr;
        cfg_next = config_index;
        unique case (st_reg)
            mpm_pkg::MPM_SYNC: st_next = mpm_pkg::MPM_SETTLE;
            // Second synchroniser stage must hold the pin before latching
            mpm_pkg::MPM_SETTLE: st_next = mpm_pkg::MPM_LATCH;
            mpm_pkg::MPM_LATCH:
            begin
                addr_next = mpm_pkg::ADDR_LUT[7 * sa_s2 +: 7];
                cfg_next = cs_s2;
                st_next = mpm_pkg::MPM_RUN;
            end
            mpm_pkg::MPM_RUN: st_next = mpm_pkg::MPM_RUN;
            default: st_next = mpm_pkg::MPM_SYNC;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sa_s1 <= 4'h0;
            sa_s2 <= 4'h0;
            cs_s1 <= 3'h0;
            cs_s2 <= 3'h0;
            st_reg <= mpm_pkg::MPM_SYNC;
            pmbus_addr <= 7'h00;
            config_index <= 3'h0;
        end
        else
        begin
            sa_s1 <= address_strap_pin;
            sa_s2 <= sa_s1;
            cs_s1 <= config_strap_pin;
            cs_s2 <= cs_s1;
            st_reg <= st_next;
            pmbus_addr <= addr_next;
            config_index <= cfg_next;
        end
    end

    // Current correction, clamps, phase counts and modulator
    logic [15:0] isns [2], vsel [2], vt_next [2], tmr_reg [2], tmr_next [2];
    logic signed [15:0] err [2];
    logic [2:0]  act_reg [2], act_next [2], nasn [2], cnt [2];
    logic [NPH-1:0] amask, o1, used, pwm_next, en_next, ls_next;
    logic [15:0] cyc_reg, cyc_next, rc_reg, rc_next, rel, off, lead;
    logic [15:0] ton, vt_q0, vt_q1;
    logic [7:0]  rw_reg, rw_next;
    logic signed [8:0]  dt;
    logic signed [33:0] prod;
    logic [18:0] dlim, alim, alim_chk;
    logic        on;

    assign isns = '{i_sense0, i_sense1};
    assign err = '{reg_err0, reg_err1};
    assign o1 = map_reg[NPH-1:0];
    assign used = map_reg[mpm_pkg::MAP_USED +: NPH];
    assign vout_target0 = vt_q0;

    always_comb
    begin
        dt = 9'(temp_sense) - mpm_pkg::T_REF;
        prod = 34'sh000000000;
        for (int o = 0; o < 2; o++)
        begin
            // Copper coefficient times temperature rise
            prod = $signed({18'h00000, isns[o]}) * $signed({1'b0, tc_reg})
                * dt;
            icor_next[o] = 16'(isns[o] - 16'(prod >>> mpm_pkg::TC_SH));
            if (prod > 0 && 16'(prod >>> mpm_pkg::TC_SH) > isns[o])
                icor_next[o] = 16'h0000;
            case (ctrl_reg[mpm_pkg::CTRL_MRG + 2 * o +: 2])
                mpm_pkg::MRG_HI: vsel[o] = vreg_reg[3 * o + 1];
                mpm_pkg::MRG_LO: vsel[o] = vreg_reg[3 * o + 2];
                default: vsel[o] = vreg_reg[3 * o];
            endcase
            vt_next[o] = vsel[o] < vlim_reg[o][15:0] ? vlim_reg[o][15:0] :
                vsel[o] > vlim_reg[o][31:16] ? vlim_reg[o][31:16] :
                vsel[o];
            nasn[o] = 3'h0;
            for (int i = 0; i < NPH; i++)
                if (used[i] && o1[i] == o[0])
                    nasn[o] = nasn[o] + 3'h1;
            dlim = 19'(th_reg[15:0]) * 19'(act_reg[o] - 3'h1);
            alim = 19'(th_reg[31:16]) * 19'(act_reg[o]);
            act_next[o] = act_reg[o];
            tmr_next[o] = 16'h0000;
            if (!ctrl_reg[mpm_pkg::CTRL_AUTO] || !ctrl_reg[mpm_pkg::CTRL_EN]
                || act_reg[o] > nasn[o])
                act_next[o] = nasn[o];
            else if (err[o] > $signed(fast_reg))
                act_next[o] = nasn[o];
            else if ({3'h0, icor_reg[o]} > alim && act_reg[o] < nasn[o])
                act_next[o] = act_reg[o] + 3'h1;
            else if ({3'h0, icor_reg[o]} < dlim && act_reg[o] > 3'h1)
            begin
                tmr_next[o] = tmr_reg[o] + 16'h0001;
                if (tmr_next[o] >= dly_reg)
                begin
                    act_next[o] = act_reg[o] - 3'h1;
                    tmr_next[o] = 16'h0000;
                end
            end
        end
        // Output zero keeps lowest phases, output one keeps highest
        cnt = '{3'h0, 3'h0};
        amask = '0;
        for (int i = 0; i < NPH; i++)
            if (used[i] && !o1[i])
            begin
                amask[i] = cnt[0] < act_reg[0];
                cnt[0] = cnt[0] + 3'h1;
            end
        for (int i = NPH - 1; i >= 0; i--)
            if (used[i] && o1[i])
            begin
                amask[i] = cnt[1] < act_reg[1];
                cnt[1] = cnt[1] + 3'h1;
            end
        // Fixed period counter; phase slots evenly spread
        cyc_next = cyc_reg >= per_reg - 16'h0001 ? 16'h0000 :
            cyc_reg + 16'h0001;
        pwm_next = '0;
        for (int i = 0; i < NPH; i++)
        begin
            off = 16'((32'(per_reg) * i) / NPH);
            rel = cyc_reg >= off ? cyc_reg - off : cyc_reg + per_reg - off;
            lead = pw_reg[o1[i]][31:16];
            ton = pw_reg[o1[i]][15:0];
            on = rel >= lead && {1'b0, rel} < {1'b0, lead} + {1'b0, ton};
            pwm_next[i] = on & amask[i] & ctrl_reg[mpm_pkg::CTRL_EN];
        end
        en_next = used & amask & {NPH{ctrl_reg[mpm_pkg::CTRL_EN]}};
        rc_next = rc_reg + 16'h0001;
        rw_next = rw_reg == 8'h00 ? 8'h00 : rw_reg - 8'h01;
        if (refr_reg != 16'h0000 && rc_reg >= refr_reg - 16'h0001)
        begin
            rc_next = 16'h0000;
            rw_next = mpm_pkg::REFR_W_CYC;
        end
        ls_next = (rw_reg != 8'h00) ? used & ~amask : '0;
    end
    assign vout_target1 = vt_q1;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            icor_reg <= '{default: 16'h0000};
            act_reg <= '{default: 3'h0};
            tmr_reg <= '{default: 16'h0000};
            cyc_reg <= 16'h0000;
            rc_reg <= 16'h0000;
            rw_reg <= 8'h00;
            pwm_out <= '0;
            pwm_en <= '0;
            lowside_on <= '0;
            vt_q0 <= 16'h0000;
            vt_q1 <= 16'h0000;
        end
        else
        begin
            icor_reg <= icor_next;
            act_reg <= act_next;
            tmr_reg <= tmr_next;
            cyc_reg <= cyc_next;
            rc_reg <= rc_next;
            rw_reg <= rw_next;
            pwm_out <= pwm_next;
            pwm_en <= en_next;
            lowside_on <= ls_next;
            vt_q0 <= vt_next[0];
            vt_q1 <= vt_next[1];
        end
    end

    // Checks on the phase manager
    chk_period_bound: assert property (@(posedge pclk)
        disable iff (!presetn) per_reg >= mpm_pkg::PER_MIN &&
        per_reg <= mpm_pkg::PER_MAX) else $error("period out of range");
    chk_vout_clamp: assert property (@(posedge pclk)
        disable iff (!presetn) vlim_reg[0][15:0] <= vlim_reg[0][31:16] &&
        $stable(vlim_reg[0]) |=> vt_q0 >= $past(vlim_reg[0][15:0]) &&
        vt_q0 <= $past(vlim_reg[0][31:16])) else $error("vout unclamped");
    chk_drop_step: assert property (@(posedge pclk)
        disable iff (!presetn) act_reg[0] < $past(act_reg[0]) &&
        $past(act_reg[0]) <= $past(nasn[0]) |->
        act_reg[0] == $past(act_reg[0]) - 3'h1) else $error("multi drop");
    chk_fast_add: assert property (@(posedge pclk)
        disable iff (!presetn) err[1] > $signed(fast_reg) |=>
        act_reg[1] == $past(nasn[1])) else $error("fast add missed");
    chk_add_now: assert property (@(posedge pclk)
        disable iff (!presetn) ctrl_reg[1:0] == 2'h3 &&
        err[0] <= $signed(fast_reg) && act_reg[0] < nasn[0] &&
        {3'h0, icor_reg[0]} > alim_chk |=>
        act_reg[0] == $past(act_reg[0]) + 3'h1) else $error("add late");
    assign alim_chk = 19'(th_reg[31:16]) * 19'(act_reg[0]);
    chk_auto_off: assert property (@(posedge pclk)
        disable iff (!presetn) !ctrl_reg[mpm_pkg::CTRL_AUTO] |=>
        act_reg[1] == $past(nasn[1])) else $error("phase count wrong");
    chk_refresh_idle: assert property (@(posedge pclk)
        disable iff (!presetn) (lowside_on & pwm_en) == '0 &&
        (lowside_on & pwm_out) == '0) else $error("refresh on live");
    chk_addr_hold: assert property (@(posedge pclk)
        disable iff (!presetn) st_reg == mpm_pkg::MPM_RUN &&
        $past(st_reg) == mpm_pkg::MPM_RUN |-> $stable(pmbus_addr) &&
        $stable(config_index)) else $error("address moved");
    chk_pwm_gate: assert property (@(posedge pclk)
        disable iff (!presetn) (pwm_out & ~pwm_en) == '0)
        else $error("pulse on idle phase");
endmodule

// ---- dv/mpm_stage_model.sv ----
`timescale 1ns/10ps
// Power stage stand-in: the load setting is the sensed current, and
// the PWM activity of every phase is timed in cycles, its refresh pulses counted
module mpm_stage_model (
    input  wire logic        pclk,
    input  wire logic [6:0]  pwm_out,
    input  wire logic [6:0]  lowside_on,
    input  wire logic [15:0] load0,
    input  wire logic [15:0] load1,
    output logic      [15:0] i_sense0,
    output logic      [15:0] i_sense1,
    output int               per_c [7],
    output int               wid_c [7],
    output int               rise_t [7],
    output int               ls_cnt [7]
);
    int         now = 0;
    logic [6:0] pwm_d = 7'h00;
    logic [6:0] ls_d = 7'h00;

    // Sense amplifiers report the applied load unchanged
    assign i_sense0 = load0;
    assign i_sense1 = load1;

    // Counters start from zero so refresh counts are absolute
    initial
    begin
        for (int i = 0; i < 7; i++)
        begin
            ls_cnt[i] = 0;
            rise_t[i] = 0;
        end
    end

    // Period, width and last rising edge per phase, refresh pulses
    always @(posedge pclk)
    begin
        now <= now + 1;
        pwm_d <= pwm_out;
        ls_d <= lowside_on;
        for (int i = 0; i < 7; i++)
        begin
            if (pwm_out[i] === 1'b1 && pwm_d[i] === 1'b0)
            begin
                per_c[i] <= now - rise_t[i];
                rise_t[i] <= now;
            end
            if (pwm_out[i] === 1'b0 && pwm_d[i] === 1'b1)
                wid_c[i] <= now - rise_t[i];
            if (lowside_on[i] === 1'b1 && ls_d[i] === 1'b0)
                ls_cnt[i] <= ls_cnt[i] + 1;
        end
    end
endmodule

// ---- dv/mpm_phase_mgr_test.sv ----
`timescale 1ns/10ps
// Register-level regression of the phase manager
module mpm_phase_mgr_test;
    logic              pclk, presetn, psel, penable, pwrite, pready;
    logic              pslverr, err;
    logic [7:0]        paddr;
    logic [31:0]       pwdata, prdata, rd;
    logic [3:0]        address_strap_pin;
    logic [2:0]        config_strap_pin, config_index;
    logic [15:0]       i_sense0, i_sense1, load0, load1;
    logic [15:0]       vout_target0, vout_target1;
    logic signed [7:0] temp_sense;
    logic signed [15:0] reg_err0, reg_err1;
    logic [6:0]        pwm_out, pwm_en, lowside_on, pmbus_addr;
    int                per_c [7], wid_c [7], rise_t [7], ls_cnt [7];
    int                n_fail, n_checks, base;
    // Target address expected for each strap level
    logic [6:0] addr_tab [16] = '{7'h60, 7'h61, 7'h64, 7'h65, 7'h40,
        7'h41, 7'h44, 7'h45, 7'h50, 7'h51, 7'h54, 7'h55, 7'h58, 7'h59,
        7'h5C, 7'h5D};

    // Free-running 125 MHz clock
    initial pclk = 1'b0;
    always #4 pclk = ~pclk;

    // Device under test and the power stages around it
    mpm_phase_mgr dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .address_strap_pin(address_strap_pin),
        .config_strap_pin(config_strap_pin), .i_sense0(i_sense0),
        .i_sense1(i_sense1), .temp_sense(temp_sense),
        .reg_err0(reg_err0), .reg_err1(reg_err1), .pwm_out(pwm_out),
        .pwm_en(pwm_en), .lowside_on(lowside_on),
        .pmbus_addr(pmbus_addr), .config_index(config_index),
        .vout_target0(vout_target0), .vout_target1(vout_target1));
    mpm_stage_model stage_u (.pclk(pclk), .pwm_out(pwm_out),
        .lowside_on(lowside_on), .load0(load0), .load1(load1),
        .i_sense0(i_sense0), .i_sense1(i_sense1), .per_c(per_c),
        .wid_c(wid_c), .rise_t(rise_t), .ls_cnt(ls_cnt));

    // Verdict and end of run
    task automatic conclude();
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Compare one value against its expectation
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer: setup, access until pready, then release
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (k >= 20)
        begin
            n_fail++;
            conclude();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(rd, e);
    endtask

    // Let a target settle, then compare output zero
    task automatic vchk(input logic [15:0] e);
        repeat (3) @(posedge pclk);
        check(32'(vout_target0), 32'(e));
    endtask

    task automatic do_reset();
        presetn <= 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
    endtask

    // Main sequence
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {address_strap_pin, config_strap_pin, reg_err0, reg_err1} = '0;
        presetn = 1'b0;
        load0 = 16'h03E8;
        load1 = 16'h03E8;
        temp_sense = 8'sh19;
        n_fail = 0;
        n_checks = 0;
        for (int s = 0; s < 16; s++)
        begin
            address_strap_pin <= 4'(s);
            config_strap_pin <= 3'(s);
            do_reset();
            check(32'(pmbus_addr), 32'(addr_tab[s]));
            check(32'(config_index), 32'(s[2:0]));
        end
        rdchk(8'h00, 32'h0);
        rdchk(8'h1C, 32'h7FFF);
        rdchk(8'h3C, 32'hFFFF_0000);
        apb(1'b0, 8'h50, 32'h0);
        check(32'(err), 32'h1);
        wr(8'h08, 32'h0A);
        rdchk(8'h08, 32'h7D);
        wr(8'h08, 32'h3E8);
        rdchk(8'h08, 32'h271);
        wr(8'h08, 32'h7D);
        // Set point and margins while regulating, clamped to limits
        wr(8'h00, 32'h1);
        wr(8'h3C, 32'h0200_0100);
        wr(8'h24, 32'h50);
        vchk(16'h0100);
        wr(8'h24, 32'h300);
        vchk(16'h0200);
        wr(8'h28, 32'h180);
        wr(8'h00, 32'h5);
        vchk(16'h0180);
        wr(8'h2C, 32'h20);
        wr(8'h00, 32'h9);
        vchk(16'h0100);
        wr(8'h30, 32'h1234);
        vchk(16'h0100);
        check(32'(vout_target1), 32'h1234);
        // Four phases on output zero, three on output one
        wr(8'h04, 32'h7F70);
        wr(8'h0C, 32'h14);
        wr(8'h10, 32'h14);
        wr(8'h14, 32'h00C8_0064);
        wr(8'h18, 32'h28);
        wr(8'h20, 32'hC8);
        wr(8'h00, 32'h1);
        repeat (300) @(posedge pclk);
        check(32'(pwm_en), 32'h7F);
        check(32'(per_c[0]), 32'h7D);
        check(32'(wid_c[0]), 32'h14);
        check(32'((rise_t[1] - rise_t[0] + 250) % 125), 32'h11);
        // Output zero's leading edge moved alone keeps the width
        wr(8'h0C, 32'h001E_0014);
        repeat (300) @(posedge pclk);
        check(32'(wid_c[0]), 32'h14);
        check(32'((rise_t[4] - rise_t[0] + 250) % 125), 32'h29);
        // Light load: one drop per delay, from the inner ends
        wr(8'h00, 32'h3);
        load0 <= 16'h32;
        load1 <= 16'h32;
        repeat (62) @(posedge pclk);
        check(32'(pwm_en), 32'h67);
        repeat (42) @(posedge pclk);
        check(32'(pwm_en), 32'h43);
        repeat (42) @(posedge pclk);
        check(32'(pwm_en), 32'h41);
        base = ls_cnt[1];
        repeat (1000) @(posedge pclk);
        check(32'(ls_cnt[1] - base >= 4 && ls_cnt[1] - base <= 6),
            32'h1);
        check(32'(ls_cnt[0]), 32'h0);
        // Heavy load restores phases without the drop delay
        load0 <= 16'h03E8;
        repeat (8) @(posedge pclk);
        check(32'(pwm_en), 32'h4F);
        wr(8'h1C, 32'h0800);
        load0 <= 16'h32;
        repeat (150) @(posedge pclk);
        check(32'(pwm_en), 32'h41);
        // Error above the fast threshold readies all phases at once
        reg_err1 <= 16'sh1000;
        reg_err0 <= 16'sh07FF;
        repeat (4) @(posedge pclk);
        check(32'(pwm_en), 32'h71);
        reg_err0 <= 16'sh0801;
        repeat (4) @(posedge pclk);
        check(32'(pwm_en), 32'h7F);
        reg_err0 <= 16'sh0;
        reg_err1 <= 16'sh0;
        wr(8'h00, 32'h1);
        repeat (150) @(posedge pclk);
        check(32'(pwm_en), 32'h7F);
        // Hot windings: sensed current scaled down by the coefficient
        wr(8'h4C, 32'h80);
        temp_sense <= 8'sh59;
        load0 <= 16'h0320;
        repeat (5) @(posedge pclk);
        rdchk(8'h48, 32'h002C_02BC);
        conclude();
    end
endmodule
